//--- common/slk_pkg.sv
// Purpose: constants, types and helpers shared by the sector lock/protect readout block
// Assumes: 20 MHz system clock, 24-bit serial address, binary 256-byte pages
// Notes: program time figure is a plain default; override through the top parameter
package slk_pkg;

  // ==================================================================
  // opcodes
  localparam logic [7:0] OP_PROT_READ = 8'h32;
  localparam logic [7:0] OP_LOCK_READ = 8'h35;
  localparam logic [7:0] OP_LOCK_B0 = 8'h3D;
  localparam logic [7:0] OP_LOCK_B1 = 8'h2A;
  localparam logic [7:0] OP_LOCK_B2 = 8'h7F;
  localparam logic [7:0] OP_LOCK_B3 = 8'h30;

  // ==================================================================
  // frame layout (byte index within a frame)
  localparam logic [2:0] IDX_DUMMY_LAST = 3'h3;
  localparam logic [2:0] IDX_ADDR_LAST = 3'h6;
  localparam int TABLE_BYTES = 16;
  localparam int FIFO_DEPTH = 4;

  // ==================================================================
  // table layout and values
  localparam logic [4:0] PROT_BASE = 5'h00;
  localparam logic [4:0] LOCK_BASE = 5'h10;
  localparam logic [7:0] BYTE_LOCKED = 8'hFF;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam int SECTOR_MSB = 19;
  localparam int SECTOR_LSB = 16;
  localparam int ZERO_LOW_MSB = 15;
  localparam int ZERO_LOW_LSB = 11;
  localparam int FLAG_ZERO_HIGH = 16;

  // ==================================================================
  // timing
  localparam longint CLK_FREQ_HZ = 20_000_000;
  localparam longint PROGRAM_TIME_US = 4000;
  localparam int PROGRAM_CYCLES = int'((PROGRAM_TIME_US * CLK_FREQ_HZ) / 1_000_000);

  typedef enum logic [2:0] {
    SLK_IDLE   = 3'b000,
    SLK_SHIFT  = 3'b001,
    SLK_ARM    = 3'b011,
    SLK_BUSY   = 3'b010,
    SLK_OUT    = 3'b101,
    SLK_IGNORE = 3'b100
  } slk_state_t;

  // one flag per lockable part: 0 = low pages of sector 0, 1..15 sectors, 16 = rest of sector 0
  function automatic logic [16:0] slk_lock_mask(input logic [23:0] addr);
    logic [3:0] sec;
    sec = addr[SECTOR_MSB:SECTOR_LSB];
    slk_lock_mask = 17'h00000;
    if (sec != 4'h0)
      slk_lock_mask[sec] = 1'b1;
    else if (addr[ZERO_LOW_MSB:ZERO_LOW_LSB] == 5'h00)
      slk_lock_mask[0] = 1'b1;
    else
      slk_lock_mask[FLAG_ZERO_HIGH] = 1'b1;
  endfunction

  function automatic logic [7:0] slk_lock_byte(input logic [16:0] flags, input logic [3:0] sec);
    if (sec == 4'h0)
      slk_lock_byte = {{2{flags[0]}}, {2{flags[FLAG_ZERO_HIGH]}}, 4'h0};
    else
      slk_lock_byte = {8{flags[sec]}};
  endfunction

endpackage

//--- common/slk_stream_if.sv
// Purpose: valid/ready byte stream between the block's own modules
// Assumes: single clock domain
// Notes: a word moves on a cycle where valid and ready are both high
`timescale 1ns/1ps
interface slk_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- verilog/slk_fifo.sv
// Purpose: small synchronous FIFO between table fetch and serial output
// Assumes: one clock, synchronous active-low reset
// Notes: flush empties it in one cycle and wins over push and pop
`timescale 1ns/1ps
module slk_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  // streams
  slk_stream_if.snk in_if,
  slk_stream_if.src out_if
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem_q[rd_q[AW-1:0]];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_if.data;
  end
endmodule

//--- verilog/slk_table_mem.sv
// Purpose: holds the protection table and the lock table, one byte per sector each
// Assumes: low half protection table, high half lock table
// Notes: read data come from a register one cycle after the read strobe
`timescale 1ns/1ps
module slk_table_mem
  import slk_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // read port
  input wire logic rd_en_i,
  input wire logic [4:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // write port
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i
);
  logic [7:0] mem_q [DEPTH];

  // reset stands for the factory-fresh contents of both tables
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= (i < int'(LOCK_BASE)) ? PROT_RESET : LOCK_RESET;
    end
    else if (wr_en_i)
      mem_q[wr_addr_i] <= wr_data_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      rd_data_o <= 8'h00;
    else if (rd_en_i)
      rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

//--- verilog/slk_top.sv
// Purpose: serial command front end for protection-table read, sector lock and lock-table read
// Assumes: serial pins come from outside the clock domain; mode 0/3 style framing
// Notes: lock is self-timed; the busy output mirrors the status busy bit
// Operation
// - a command starts only after select goes low, then opcode bytes follow
// - after dummies, sixteen protection bytes shift out, sector 0 first
// - clocks beyond the sixteenth protection byte give undefined output; here zero bits shift out
// - select high aborts the protection read and floats serial output
// - three address bytes follow; device resolves them to a sector
// - lock starts only when select rises after the last address bit
// - status shows busy while the lock runs, at most program time
// - locked sectors refuse erase and program and never unlock; here resetn_i clears every lock
// - lock table has one byte per sector; FFH locked, 00H unlocked
// - sector 0 byte uses bits 7:6 and 5:4, low nibble zero
// - after dummies, sixteen lock bytes shift out, sector 0 first
// - clocks beyond the last lock byte give undefined output; here zero bits shift out
// - select high ends the lock-table read and floats serial output
// - protection bytes FFH protected, 00H unprotected, others undefined
`timescale 1ns/1ps
module slk_top
  import slk_pkg::*;
#(
  parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial pins
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // status
  output logic busy_o,
  // erase/program guard for the array logic
  input wire logic modify_req_i,
  input wire logic [23:0] modify_addr_i,
  output logic modify_refuse_o
);
  localparam int PIN_SEL = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_DAT = 2;
  localparam int BW = $clog2(PROG_CYCLES + 1);

  // ==================================================================
  // pin synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] filt_q;
  logic [2:0] filt_prev_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      sync1_q <= 3'h1;
      sync2_q <= 3'h1;
      sync3_q <= 3'h1;
    end
    else
    begin
      sync1_q <= {sdi_i, sclk_i, sel_n_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a level counts only once the second and third stage agree
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      filt_q <= 3'h1;
      filt_prev_q <= 3'h1;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (sync2_q[i] == sync3_q[i])
          filt_q[i] <= sync3_q[i];
      filt_prev_q <= filt_q;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic clk_rise;
  logic clk_fall;
  logic sel_active;

  assign sel_fall = filt_prev_q[PIN_SEL] && !filt_q[PIN_SEL];
  assign sel_rise = !filt_prev_q[PIN_SEL] && filt_q[PIN_SEL];
  assign sel_active = !filt_q[PIN_SEL];
  assign clk_rise = !filt_prev_q[PIN_CLK] && filt_q[PIN_CLK] && sel_active;
  assign clk_fall = filt_prev_q[PIN_CLK] && !filt_q[PIN_CLK] && sel_active;

  // ==================================================================
  // receive shifter
  slk_state_t state_q;
  logic [6:0] rx_sr_q;
  logic [2:0] rx_bit_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic receiving;

  assign receiving = (state_q == SLK_SHIFT);
  assign rx_byte = {rx_sr_q, filt_q[PIN_DAT]};
  assign byte_done = receiving && clk_rise && (rx_bit_q == 3'h7);

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || sel_fall)
    begin
      rx_sr_q <= 7'h00;
      rx_bit_q <= 3'h0;
      rx_idx_q <= 3'h0;
    end
    else if (receiving && clk_rise)
    begin
      rx_sr_q <= rx_byte[6:0];
      rx_bit_q <= rx_bit_q + 3'h1;
      if (rx_bit_q == 3'h7)
        rx_idx_q <= rx_idx_q + 3'h1;
    end
  end

  // ==================================================================
  // command decode and sequencing
  logic lock_mode_q;
  logic [4:0] rd_base_q;
  logic [23:0] addr_q;
  logic [BW-1:0] busy_cnt_q;
  logic lock_go;
  logic lock_seq_ok;

  always_comb
  begin
    unique case (rx_idx_q)
      3'h1: lock_seq_ok = (rx_byte == OP_LOCK_B1);
      3'h2: lock_seq_ok = (rx_byte == OP_LOCK_B2);
      3'h3: lock_seq_ok = (rx_byte == OP_LOCK_B3);
      default: lock_seq_ok = 1'b1;
    endcase
  end

  assign lock_go = (state_q == SLK_ARM) && sel_rise;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      state_q <= SLK_IDLE;
      lock_mode_q <= 1'b0;
      rd_base_q <= PROT_BASE;
    end
    else
    begin
      unique case (state_q)
        SLK_IDLE:
          if (sel_fall)
            state_q <= SLK_SHIFT;
        SLK_SHIFT:
          if (sel_rise)
            state_q <= SLK_IDLE;
          else if (byte_done)
          begin
            if (rx_idx_q == 3'h0)
            begin
              lock_mode_q <= (rx_byte == OP_LOCK_B0);
              rd_base_q <= (rx_byte == OP_LOCK_READ) ? LOCK_BASE : PROT_BASE;
              if (rx_byte != OP_PROT_READ && rx_byte != OP_LOCK_READ && rx_byte != OP_LOCK_B0)
                state_q <= SLK_IGNORE;
            end
            else if (lock_mode_q)
            begin
              if (!lock_seq_ok)
                state_q <= SLK_IGNORE;
              else if (rx_idx_q == IDX_ADDR_LAST)
                state_q <= SLK_ARM;
            end
            else if (rx_idx_q == IDX_DUMMY_LAST)
              state_q <= SLK_OUT;
          end
        SLK_ARM:
          if (lock_go)
            state_q <= SLK_BUSY;
          else if (clk_rise)
            state_q <= SLK_IGNORE;
        SLK_BUSY:
          if (busy_cnt_q == '0)
            state_q <= sel_active ? SLK_IGNORE : SLK_IDLE;
        SLK_OUT:
          if (sel_rise)
            state_q <= SLK_IDLE;
        SLK_IGNORE:
          if (sel_rise)
            state_q <= SLK_IDLE;
        default:
          state_q <= SLK_IDLE;
      endcase
    end
  end

  // address bytes, msb first
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      addr_q <= 24'h000000;
    else if (byte_done && lock_mode_q && rx_idx_q > IDX_DUMMY_LAST)
      addr_q <= {addr_q[15:0], rx_byte};
  end

  // ==================================================================
  // self-timed lock and lock state
  logic [16:0] lock_flags_q;
  logic [16:0] lock_flags_d;
  logic [3:0] lock_sec;

  assign lock_sec = addr_q[SECTOR_MSB:SECTOR_LSB];
  assign lock_flags_d = lock_flags_q | slk_lock_mask(addr_q);

  // flags only ever gain bits
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      lock_flags_q <= 17'h00000;
    else if (lock_go)
      lock_flags_q <= lock_flags_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      busy_cnt_q <= '0;
      busy_o <= 1'b0;
    end
    else if (lock_go)
    begin
      busy_cnt_q <= BW'(PROG_CYCLES - 1);
      busy_o <= 1'b1;
    end
    else if (state_q == SLK_BUSY)
    begin
      if (busy_cnt_q == '0)
        busy_o <= 1'b0;
      else
        busy_cnt_q <= busy_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      modify_refuse_o <= 1'b0;
    else
      modify_refuse_o <= modify_req_i && ((slk_lock_mask(modify_addr_i) & lock_flags_q) != 17'h00000);
  end

  // ==================================================================
  // table memory and prefetch into the FIFO
  logic fetch_en_q;
  logic fetch_pend_q;
  logic [4:0] fetch_cnt_q;
  logic fetch_issue;
  logic flush;
  logic [7:0] mem_rdata;

  slk_stream_if #(.W(8)) fill_if ();
  slk_stream_if #(.W(8)) drain_if ();

  assign flush = sel_rise || (state_q == SLK_IDLE);
  assign fetch_issue = fetch_en_q && !fetch_pend_q && (fetch_cnt_q < 5'(TABLE_BYTES)) && fill_if.ready;
  assign fill_if.valid = fetch_pend_q && fetch_en_q;
  assign fill_if.data = mem_rdata;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || flush)
    begin
      fetch_en_q <= 1'b0;
      fetch_pend_q <= 1'b0;
      fetch_cnt_q <= 5'h00;
    end
    else
    begin
      if (byte_done && rx_idx_q == 3'h0 && (rx_byte == OP_PROT_READ || rx_byte == OP_LOCK_READ))
        fetch_en_q <= 1'b1;
      fetch_pend_q <= fetch_issue;
      if (fetch_issue)
        fetch_cnt_q <= fetch_cnt_q + 5'h01;
    end
  end

  slk_table_mem #(
    .DEPTH(32)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .rd_en_i(fetch_issue),
    .rd_addr_i(rd_base_q + fetch_cnt_q),
    .rd_data_o(mem_rdata),
    .wr_en_i(lock_go),
    .wr_addr_i(LOCK_BASE + {1'b0, lock_sec}),
    .wr_data_i(slk_lock_byte(lock_flags_d, lock_sec))
  );

  slk_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flush_i(flush),
    .in_if(fill_if),
    .out_if(drain_if)
  );

  // ==================================================================
  // output serialiser
  logic [6:0] tx_sr_q;
  logic [2:0] tx_bit_q;
  logic [4:0] tx_cnt_q;
  logic tx_load;
  logic tx_have;

  assign tx_load = (state_q == SLK_OUT) && clk_fall && (tx_bit_q == 3'h0);
  assign tx_have = (tx_cnt_q < 5'(TABLE_BYTES)) && drain_if.valid;
  assign drain_if.ready = tx_load && (tx_cnt_q < 5'(TABLE_BYTES));

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || state_q != SLK_OUT)
    begin
      tx_sr_q <= 7'h00;
      tx_bit_q <= 3'h0;
      tx_cnt_q <= 5'h00;
    end
    else if (clk_fall)
    begin
      tx_bit_q <= tx_bit_q + 3'h1;
      if (tx_load)
      begin
        tx_sr_q <= tx_have ? drain_if.data[6:0] : 7'h00;
        if (tx_cnt_q < 5'(TABLE_BYTES))
          tx_cnt_q <= tx_cnt_q + 5'h01;
      end
      else
        tx_sr_q <= {tx_sr_q[5:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || sel_rise || state_q != SLK_OUT)
    begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      sdo_oe_o <= 1'b1;
      if (tx_load)
        sdo_o <= tx_have ? drain_if.data[7] : 1'b0;
      else if (clk_fall)
        sdo_o <= tx_sr_q[6];
    end
  end

endmodule

//--- bench/slk_host_model.sv
// Purpose: host controller model driving the serial select, clock and data pins
// Assumes: clock idles low between frames; each clock phase lasts 4 system clocks (400 ns period)
// Notes: reply bits are sampled at the end of the high phase; x is returned while the output floats
`timescale 1ns/1ps
module slk_host_model (
  // clock
  input wire logic clk_sys_i,
  // serial pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // ==================================================================
  // framing
  task automatic start_frame();
    wait_clk(1);
    sel_n_o = 1'b0;
    wait_clk(8);
  endtask

  task automatic end_frame();
    sclk_o = 1'b0;
    wait_clk(4);
    sel_n_o = 1'b1;
    sdi_o = ~sdi_o;
    wait_clk(8);
  endtask

  // ==================================================================
  // one byte each way, msb first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      sdi_o = tx[i];
      wait_clk(4);
      sclk_o = 1'b1;
      wait_clk(4);
      rx[i] = (sdo_oe_i === 1'b1) ? sdo_i : 1'bx;
    end
  endtask
endmodule

//--- bench/slk_top_assertions.sv
// Purpose: concurrent checks on the serial front end ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: busy length is counted in helper logic
`timescale 1ns/1ps
module slk_top_assertions
  import slk_pkg::*;
#(
  parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial pins
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  // status and guard
  input wire logic busy_o,
  input wire logic modify_req_i,
  input wire logic [23:0] modify_addr_i,
  input wire logic modify_refuse_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  logic [31:0] busy_cnt_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || !busy_o)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end

  // ==================================================================
  // sequences and properties
  sequence s_sel_idle;
    sel_n_i [*8];
  endsequence
  sequence s_deselect;
    $rose(sel_n_i);
  endsequence

  property p_oe_start;
    $rose(sdo_oe_o) |-> !sel_n_i && !$past(sel_n_i, 100);
  endproperty
  property p_oe_idle;
    s_sel_idle |-> !sdo_oe_o;
  endproperty
  property p_oe_end;
    s_deselect |-> ##[1:8] !sdo_oe_o;
  endproperty
  property p_busy_start;
    $rose(busy_o) |-> sel_n_i && $past(sel_n_i, 3);
  endproperty
  property p_busy_max;
    busy_cnt_q <= PROG_CYCLES + 1;
  endproperty
  property p_busy_min;
    $fell(busy_o) |-> busy_cnt_q >= PROG_CYCLES - 1;
  endproperty
  property p_sdo_fall;
    sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> !$past(sclk_i, 5) || !$past(sclk_i, 6);
  endproperty
  property p_refuse_cause;
    modify_refuse_o |-> $past(modify_req_i) || $past(modify_req_i, 2);
  endproperty

  a_oe_start: assert property (p_oe_start)
    else $error("output enabled without a full command frame");
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  a_oe_end: assert property (p_oe_end)
    else $error("output not released after deselect");
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose while selected");
  a_busy_max: assert property (p_busy_max)
    else $error("busy longer than program time");
  a_busy_min: assert property (p_busy_min)
    else $error("busy shorter than program time");
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("output bit changed away from a falling clock");
  a_refuse_cause: assert property (p_refuse_cause)
    else $error("refusal without a modify request");
endmodule

bind slk_top slk_top_assertions #(
  .PROG_CYCLES(PROG_CYCLES)
) i_slk_top_assertions (
  .clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i),
  .sel_n_i(sel_n_i),
  .sclk_i(sclk_i),
  .sdi_i(sdi_i),
  .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o),
  .busy_o(busy_o),
  .modify_req_i(modify_req_i),
  .modify_addr_i(modify_addr_i),
  .modify_refuse_o(modify_refuse_o)
);

//--- bench/tb_slk_top.sv
// Purpose: table reads, sector lock and modify guard through the serial pins
// Assumes: program time shortened to 20 clocks
// Notes: expected tables start at 00H after reset
`timescale 1ns/1ps
module tb_slk_top;
  import slk_pkg::*;
  localparam int PROG = 20;
  localparam logic [31:0] LOCK_OP = {OP_LOCK_B0, OP_LOCK_B1, OP_LOCK_B2, OP_LOCK_B3};
  logic clk_sys_i, resetn_i, sel_n, sclk, sdi, sdo, sdo_oe, busy, mreq, mref;
  logic [23:0] maddr;
  logic [7:0] exp_q [0:15];
  int fails, tests_run;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  slk_top #(.PROG_CYCLES(PROG)) i_slk_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sel_n_i(sel_n),
    .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .busy_o(busy), .modify_req_i(mreq),
    .modify_addr_i(maddr), .modify_refuse_o(mref));
  slk_host_model i_slk_host_model (.clk_sys_i(clk_sys_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  // ==================================================================
  // compares
  task automatic check1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  // ==================================================================
  // access tasks
  task automatic read_table(input logic [7:0] op, input int n);
    logic [7:0] rx;
    i_slk_host_model.start_frame();
    i_slk_host_model.xfer(op, rx);
    for (int i = 0; i < 3; i++)
      i_slk_host_model.xfer(8'hA5 ^ 8'(i), rx);
    for (int i = 0; i < n; i++)
    begin
      i_slk_host_model.xfer(8'h3C, rx);
      check8(rx, (op == OP_PROT_READ || i > 15) ? 8'h00 : exp_q[i]);
    end
    i_slk_host_model.end_frame();
    check1(sdo_oe, 1'b0);
  endtask

  task automatic lock(input logic [31:0] op, input logic [23:0] a, input logic exp_busy);
    logic [7:0] rx;
    i_slk_host_model.start_frame();
    for (int i = 3; i >= 0; i--)
      i_slk_host_model.xfer(op[8*i+:8], rx);
    for (int i = 2; i >= 0; i--)
      i_slk_host_model.xfer(a[8*i+:8], rx);
    check1(busy, 1'b0);
    i_slk_host_model.end_frame();
    check1(busy, exp_busy);
    i_slk_host_model.wait_clk(30);
    check1(busy, 1'b0);
  endtask

  // one-cycle request; the refusal stands only in the cycle after it
  task automatic guard(input logic [23:0] a, input logic exp);
    mreq = 1'b1;
    maddr = a;
    @(posedge clk_sys_i);
    #1;
    mreq = 1'b0;
    check1(mref, exp);
    @(posedge clk_sys_i);
    #1;
    check1(mref, 1'b0);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==================================================================
  // tests
  initial
  begin
    #2_000_000;
    fails++;
    conclude();
  end

  initial
  begin
    resetn_i = 1'b0;
    mreq = 1'b0;
    maddr = 24'h000000;
    exp_q = '{default: 8'h00};
    repeat (2) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    read_table(OP_PROT_READ, 17);
    read_table(OP_LOCK_READ, 17);
    lock({OP_LOCK_B0, OP_LOCK_B1, OP_LOCK_B2, 8'h31}, 24'h031234, 1'b0);
    lock({OP_LOCK_B1, OP_LOCK_B0, OP_LOCK_B2, OP_LOCK_B3}, 24'h031234, 1'b0);
    lock(LOCK_OP, 24'h05ABCD, 1'b1);
    lock(LOCK_OP, 24'h0007FF, 1'b1);
    exp_q[0] = 8'hC0;
    exp_q[5] = 8'hFF;
    read_table(OP_LOCK_READ, 2);
    read_table(OP_LOCK_READ, 17);
    guard(24'h050000, 1'b1);
    guard(24'h04FFFF, 1'b0);
    guard(24'h000000, 1'b1);
    guard(24'h000800, 1'b0);
    lock(LOCK_OP, 24'h051234, 1'b1);
    lock(LOCK_OP, 24'h00F000, 1'b1);
    lock(LOCK_OP, 24'h0FFFFF, 1'b1);
    exp_q[0] = 8'hF0;
    exp_q[15] = 8'hFF;
    read_table(OP_LOCK_READ, 18);
    guard(24'h000800, 1'b1);
    guard(24'h0F0000, 1'b1);
    read_table(OP_PROT_READ, 16);
    conclude();
  end
endmodule
